// file: core/excitation_bias_regs.sv
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "excitation_bias_consts.svh"

module excitation_bias_regs
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output excitation_bias_pkg::excitation_drive_t excitationDrive,
  output excitation_bias_pkg::route_pins_t sourceOnePins,
  output excitation_bias_pkg::route_pins_t sourceTwoPins,
  output excitation_bias_pkg::bias_drive_t biasDrive,
  output logic biasActive
);
  import excitation_bias_pkg::*;

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************

  // Codes above the largest step are treated as off.
  function automatic logic [3:0] effectiveMagnitude(input logic [7:0] magReg);
    logic [3:0] code;
    code = magReg[3:0];
    if (code > `MAG_MAX_CODE)
    begin
      effectiveMagnitude = 4'h0;
    end
    else
    begin
      effectiveMagnitude = code;
    end
  endfunction

  // Register index of a byte address; unaligned low bits are ignored.
  function automatic logic [5:0] regIndex(input logic [7:0] addr);
    regIndex = addr[7:2];
  endfunction

  function automatic logic indexMapped(input logic [5:0] idx);
    indexMapped = (idx == `MAG_IDX) || (idx == `ROUTE_IDX) || (idx == `BIAS_IDX) ||
      (idx == `DEV_CTRL_IDX) || (idx == `STATUS_IDX);
  endfunction

  // ****************************************************************
  // Register storage.
  // ****************************************************************
  logic [7:0] mag_reg;
  logic [7:0] route_reg;
  logic [7:0] bias_reg;
  logic [7:0] devCtrl_reg;
  logic [7:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb_reg;
  logic doWrite;
  logic [5:0] writeIdx;
  logic [7:0] status;
  logic [7:0] readByte;
  logic [5:0] readIdx;
  logic powerDown;
  logic sixInputVariant;
  logic [3:0] magnitude_next;
  logic switchClose_next;
  logic biasActive_next;
  route_pins_t sourceOne_next;
  route_pins_t sourceTwo_next;

  assign powerDown = devCtrl_reg[`DEV_POWER_DOWN_BIT];
  assign sixInputVariant = devCtrl_reg[`DEV_SIX_INPUT_BIT];

  // ****************************************************************
  // Write address and data channels.
  // ****************************************************************

  // Each channel is taken on its own handshake and held until both are
  // present; the ready stays low from the take until the response is
  // accepted, so only one write is ever in flight.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      awready <= 1'b1;
      awaddr_reg <= 8'h00;
    end
    else if (awvalid && awready)
    begin
      awready <= 1'b0;
      awaddr_reg <= awaddr;
    end
    else if (bvalid && bready)
    begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      wready <= 1'b1;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
    end
    else if (wvalid && wready)
    begin
      wready <= 1'b0;
      wdata_reg <= wdata[7:0];
      wstrb_reg <= wstrb[0];
    end
    else if (bvalid && bready)
    begin
      wready <= 1'b1;
    end
  end

  assign doWrite = !awready && !wready && !bvalid;
  assign writeIdx = regIndex(awaddr_reg);

  // ****************************************************************
  // Write response channel.
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (doWrite)
    begin
      bvalid <= 1'b1;
      bresp <= indexMapped(writeIdx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bvalid && bready)
    begin
      bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************

  // Only the low byte lane carries register data; a write without it
  // completes normally and leaves the register alone.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      mag_reg <= `MAG_RESET;
    end
    else if (doWrite && wstrb_reg && (writeIdx == `MAG_IDX))
    begin
      mag_reg <= wdata_reg & `MAG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      route_reg <= `ROUTE_RESET;
    end
    else if (doWrite && wstrb_reg && (writeIdx == `ROUTE_IDX))
    begin
      route_reg <= wdata_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      bias_reg <= `BIAS_RESET;
    end
    else if (doWrite && wstrb_reg && (writeIdx == `BIAS_IDX))
    begin
      bias_reg <= wdata_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      devCtrl_reg <= `DEV_CTRL_RESET;
    end
    else if (doWrite && wstrb_reg && (writeIdx == `DEV_CTRL_IDX))
    begin
      devCtrl_reg <= wdata_reg & `DEV_CTRL_MASK;
    end
  end

  // ****************************************************************
  // Read channel.
  // ****************************************************************
  assign readIdx = regIndex(araddr);

  // The status view reports what actually drives the analog section,
  // which differs from the stored bits in power-down or on bad codes.
  assign status = {3'b000, biasActive, |excitationDrive.magnitude,
    |sourceTwoPins, |sourceOnePins, excitationDrive.lowSideSwitchClose};

  always_comb
  begin
    unique case (readIdx)
      `MAG_IDX: readByte = mag_reg & `MAG_WRITE_MASK;
      `ROUTE_IDX: readByte = route_reg;
      `BIAS_IDX: readByte = bias_reg;
      `DEV_CTRL_IDX: readByte = devCtrl_reg;
      `STATUS_IDX: readByte = status;
      default: readByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, readByte};
      rresp <= indexMapped(readIdx) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Current source routing.
  // ****************************************************************
  excitation_route_decode sourceOneDecode
  (
    .routeCode(route_reg[`ROUTE_ONE_LSB +: 4]),
    .sixInputVariant(sixInputVariant),
    .pins(sourceOne_next)
  );

  excitation_route_decode sourceTwoDecode
  (
    .routeCode(route_reg[`ROUTE_TWO_LSB +: 4]),
    .sixInputVariant(sixInputVariant),
    .pins(sourceTwo_next)
  );

  // ****************************************************************
  // Analog control outputs.
  // ****************************************************************

  // The stored switch bit survives power-down so the switch closes again
  // on wake-up without software rewriting it.
  assign switchClose_next = mag_reg[`MAG_SWITCH_BIT] && !powerDown;
  assign magnitude_next = effectiveMagnitude(mag_reg);
  assign biasActive_next = |bias_reg[6:0];

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      excitationDrive <= '0;
    end
    else
    begin
      excitationDrive.railMonitorEnable <= mag_reg[`MAG_RAIL_BIT];
      excitationDrive.lowSideSwitchClose <= switchClose_next;
      excitationDrive.magnitude <= magnitude_next;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sourceOnePins <= '0;
      sourceTwoPins <= '0;
    end
    else
    begin
      sourceOnePins <= sourceOne_next;
      sourceTwoPins <= sourceTwo_next;
    end
  end

  // The level bit is passed on even when no input is chosen; the output
  // stays idle through biasActive and cleared enables in that case.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      biasDrive <= '0;
      biasActive <= 1'b0;
    end
    else
    begin
      biasDrive.levelSelect <= bias_reg[`BIAS_LEVEL_BIT];
      biasDrive.commonEnable <= bias_reg[6];
      biasDrive.inputEnable <= bias_reg[5:0];
      biasActive <= biasActive_next;
    end
  end

endmodule

// file: core/excitation_route_decode.sv
`timescale 1ns/1ns
`include "excitation_bias_consts.svh"

module excitation_route_decode
(
  input wire logic [3:0] routeCode,
  input wire logic sixInputVariant,
  output excitation_bias_pkg::route_pins_t pins
);
  import excitation_bias_pkg::*;

  // ****************************************************************
  // Channel coding shared by both current sources.
  // ****************************************************************
  always_comb
  begin
    pins = '0;
    if (routeCode == `ROUTE_COMMON)
    begin
      pins.commonInput = 1'b1;
    end
    else if (sixInputVariant)
    begin
      // The smaller package has no inputs above five; two codes reach
      // the second reference pair, the rest leave the source open.
      if (routeCode <= `ROUTE_LAST_SIX)
      begin
        pins.analogInput[routeCode] = 1'b1;
      end
      else if (routeCode == `ROUTE_REF_POS)
      begin
        pins.refPositive = 1'b1;
      end
      else if (routeCode == `ROUTE_REF_NEG)
      begin
        pins.refNegative = 1'b1;
      end
    end
    else if (routeCode <= `ROUTE_LAST_AIN)
    begin
      pins.analogInput[routeCode] = 1'b1;
    end
  end

endmodule

// file: pkg/excitation_bias_consts.svh
// Overview of operation
// - Magnitude bit 7 enables rail monitor.
// - Magnitude bit 6 closes low-side switch.
// - Power-down forces low-side switch open.
// - Magnitude code sets current; 1010-1111 off.
// - One magnitude drives both current sources.
// - Routing bits 7:4 place source two.
// - Routing bits 3:0 place source one.
// - Six-input variant: 0110/0111 reach references.
// - Routing register index 07h, reset FFh.
// - Magnitude register index 06h, reset 00h.
// - Bias register index 08h, reset 00h.
// - Level bit picks bias; no input, none.
// - Any bias input combination allowed together.
`ifndef EXCITATION_BIAS_CONSTS_SVH
`define EXCITATION_BIAS_CONSTS_SVH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define MAG_IDX 6'h06
`define ROUTE_IDX 6'h07
`define BIAS_IDX 6'h08
`define DEV_CTRL_IDX 6'h0a
`define STATUS_IDX 6'h0b

// ****************************************************************
// Reset values.
// ****************************************************************
`define MAG_RESET 8'h00
`define ROUTE_RESET 8'hff
`define BIAS_RESET 8'h00
`define DEV_CTRL_RESET 8'h00

// ****************************************************************
// Field positions and codes.
// ****************************************************************
`define MAG_RAIL_BIT 7
`define MAG_SWITCH_BIT 6
`define MAG_WRITE_MASK 8'hcf
`define MAG_MAX_CODE 4'h9
`define ROUTE_TWO_LSB 4
`define ROUTE_ONE_LSB 0
`define ROUTE_COMMON 4'hc
`define ROUTE_LAST_AIN 4'hb
`define ROUTE_LAST_SIX 4'h5
`define ROUTE_REF_POS 4'h6
`define ROUTE_REF_NEG 4'h7
`define BIAS_LEVEL_BIT 7
`define DEV_POWER_DOWN_BIT 0
`define DEV_SIX_INPUT_BIT 1
`define DEV_CTRL_MASK 8'h03

// ****************************************************************
// Bus answers.
// ****************************************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: pkg/excitation_bias_pkg.sv
package excitation_bias_pkg;

  // Pin selection of one excitation current source.
  typedef struct packed {
    logic [11:0] analogInput;
    logic commonInput;
    logic refPositive;
    logic refNegative;
  } route_pins_t;

  // Sensor bias output controls.
  typedef struct packed {
    logic levelSelect;
    logic commonEnable;
    logic [5:0] inputEnable;
  } bias_drive_t;

  // Shared magnitude and supervision controls.
  typedef struct packed {
    logic railMonitorEnable;
    logic lowSideSwitchClose;
    logic [3:0] magnitude;
  } excitation_drive_t;

endpackage

// file: verification/excitation_bias_regs_chk.sv
`timescale 1ns/1ns
`include "excitation_bias_consts.svh"

module excitation_bias_regs_chk
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input excitation_bias_pkg::excitation_drive_t excitationDrive,
  input excitation_bias_pkg::route_pins_t sourceOnePins,
  input excitation_bias_pkg::route_pins_t sourceTwoPins,
  input excitation_bias_pkg::bias_drive_t biasDrive,
  input wire logic biasActive
);
  import excitation_bias_pkg::*;
  // ****************************************************************
  // Shadow registers.
  // ****************************************************************
  // The shadow commits when bvalid first shows, so it lines up with the one-cycle output lag.
  logic [5:0] awIdx;
  logic [7:0] wByte, magSh, routeSh, biasSh, devSh;
  logic wEn, bvPrev;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      magSh <= `MAG_RESET;
      routeSh <= `ROUTE_RESET;
      biasSh <= `BIAS_RESET;
      devSh <= `DEV_CTRL_RESET;
      bvPrev <= 1'b0;
    end
    else
    begin
      bvPrev <= bvalid;
      if (awvalid && awready)
        awIdx <= awaddr[7:2];
      if (wvalid && wready)
        {wEn, wByte} <= {wstrb[0], wdata[7:0]};
      if (bvalid && !bvPrev && wEn && awIdx == `MAG_IDX)
        magSh <= wByte;
      if (bvalid && !bvPrev && wEn && awIdx == `ROUTE_IDX)
        routeSh <= wByte;
      if (bvalid && !bvPrev && wEn && awIdx == `BIAS_IDX)
        biasSh <= wByte;
      if (bvalid && !bvPrev && wEn && awIdx == `DEV_CTRL_IDX)
        devSh <= wByte;
    end
  end
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  chk_rail_enable: assert property (
    excitationDrive.railMonitorEnable == magSh[`MAG_RAIL_BIT]) else $error("rail monitor bad");
  chk_switch_close: assert property (
    excitationDrive.lowSideSwitchClose == (magSh[6] && !devSh[0])) else $error("switch bad");
  chk_switch_pd: assert property (
    devSh[0] |-> !excitationDrive.lowSideSwitchClose) else $error("switch closed in power-down");
  chk_mag_code: assert property (
    excitationDrive.magnitude == ((magSh[3:0] > `MAG_MAX_CODE) ? 4'h0 : magSh[3:0]))
    else $error("magnitude bad");
  chk_route_idle: assert property (
    (routeSh[3:0] > `ROUTE_COMMON) |-> sourceOnePins == '0) else $error("source one not idle");
  chk_route_common: assert property (
    sourceTwoPins.commonInput == (routeSh[7:4] == `ROUTE_COMMON)) else $error("common bad");
  chk_route_ref: assert property (
    sourceOnePins.refPositive == (devSh[1] && routeSh[3:0] == `ROUTE_REF_POS))
    else $error("reference pin bad");
  chk_bias_copy: assert property (
    biasDrive == biasSh) else $error("bias drive bad");
  chk_bias_active: assert property (
    biasActive == (|biasSh[6:0])) else $error("bias active bad");
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("no write answer");
  chk_read_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data dropped");
endmodule

bind excitation_bias_regs excitation_bias_regs_chk chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .excitationDrive(excitationDrive),
  .sourceOnePins(sourceOnePins), .sourceTwoPins(sourceTwoPins), .biasDrive(biasDrive),
  .biasActive(biasActive));

// file: verification/excitation_bias_regs_tb.sv
`timescale 1ns/1ns
`include "excitation_bias_consts.svh"

module excitation_bias_regs_tb;
  import excitation_bias_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, biasActive;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  excitation_drive_t excitationDrive;
  route_pins_t sourceOnePins, sourceTwoPins;
  bias_drive_t biasDrive;
  int failures = 0;
  int n_checks = 0;
  logic [3:0] strobe = 4'h1;
  always #50 clk_sys = ~clk_sys;

  excitation_bias_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .excitationDrive(excitationDrive), .sourceOnePins(sourceOnePins),
    .sourceTwoPins(sourceTwoPins), .biasDrive(biasDrive), .biasActive(biasActive));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic answered(input logic seen);
    if (seen !== 1'b1)
    begin
      failures++;
      $display("mismatch at %0t: bus answer never came", $time);
      complete_run();
    end
  endtask

  // Returns one cycle after the answer, when the drive outputs have taken the new value.
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] expResp);
    int n;
    n = 0;
    @(posedge clk_sys);
    {awaddr, wdata, wstrb} <= {idx, 2'b00, 24'h000000, d, strobe};
    {awvalid, wvalid, bready} <= 3'b111;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    answered(bvalid);
    cmp({30'h0, bresp}, {30'h0, expResp}, "write response");
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] expData, input logic [1:0] expResp);
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= {idx, 2'b00};
    {arvalid, rready} <= 2'b11;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    answered(rvalid);
    cmp(rdata, {24'h0, expData}, "read data");
    cmp({30'h0, rresp}, {30'h0, expResp}, "read response");
  endtask

  function automatic route_pins_t pinsFor(input logic [3:0] code, input logic six);
    route_pins_t p;
    p = '0;
    if (code == `ROUTE_COMMON)
      p.commonInput = 1'b1;
    else if (six && code == `ROUTE_REF_POS)
      p.refPositive = 1'b1;
    else if (six && code == `ROUTE_REF_NEG)
      p.refNegative = 1'b1;
    else if (code <= (six ? `ROUTE_LAST_SIX : `ROUTE_LAST_AIN))
      p.analogInput[code] = 1'b1;
    return p;
  endfunction

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic testReset();
    cmp(32'(excitationDrive), 32'h0, "drive after reset");
    cmp(32'(sourceOnePins) | 32'(sourceTwoPins), 32'h0, "routes after reset");
    rd(`MAG_IDX, `MAG_RESET, `RESP_OKAY);
    rd(`ROUTE_IDX, `ROUTE_RESET, `RESP_OKAY);
    rd(`BIAS_IDX, `BIAS_RESET, `RESP_OKAY);
    $display("reset test done");
  endtask

  // Ones go into the reserved bits on purpose to show they never stick.
  // The internal reference sits outside this block; the bench acts as software that
  // already has it on before any current is programmed.
  task automatic testMagnitude();
    for (int c = 0; c < 16; c++)
    begin
      wr(`MAG_IDX, {4'hf, c[3:0]}, `RESP_OKAY);
      cmp(32'(excitationDrive), {26'h0, 2'b11, (c > 9) ? 4'h0 : c[3:0]}, "mag");
      rd(`MAG_IDX, {4'hc, c[3:0]}, `RESP_OKAY);
    end
    wr(`MAG_IDX, 8'h45, `RESP_OKAY);
    cmp(32'(excitationDrive), 32'h15, "switch closed");
    wr(`DEV_CTRL_IDX, 8'h01, `RESP_OKAY);
    cmp(32'(excitationDrive), 32'h05, "switch in power-down");
    rd(`MAG_IDX, 8'h45, `RESP_OKAY);
    rd(`STATUS_IDX, 8'h08, `RESP_OKAY);
    wr(`DEV_CTRL_IDX, 8'h00, `RESP_OKAY);
    cmp(32'(excitationDrive), 32'h15, "switch after wake");
    rd(`STATUS_IDX, 8'h09, `RESP_OKAY);
    $display("magnitude test done");
  endtask

  task automatic testRouting();
    for (int s = 0; s < 2; s++)
    begin
      wr(`DEV_CTRL_IDX, {6'h0, s[0], 1'b0}, `RESP_OKAY);
      for (int c = 0; c < 16; c++)
      begin
        wr(`ROUTE_IDX, {c[3:0], ~c[3:0]}, `RESP_OKAY);
        cmp(32'(sourceTwoPins), 32'(pinsFor(c[3:0], s[0])), "source two");
        cmp(32'(sourceOnePins), 32'(pinsFor(~c[3:0], s[0])), "source one");
      end
    end
    rd(`ROUTE_IDX, 8'hf0, `RESP_OKAY);
    $display("routing test done");
  endtask

  task automatic testBias();
    logic [7:0] v [4] = '{8'h80, 8'h7f, 8'hc1, 8'h20};
    foreach (v[i])
    begin
      wr(`BIAS_IDX, v[i], `RESP_OKAY);
      cmp({24'h0, biasDrive}, {24'h0, v[i]}, "bias drive");
      cmp({31'h0, biasActive}, {31'h0, |v[i][6:0]}, "bias active");
      rd(`BIAS_IDX, v[i], `RESP_OKAY);
    end
    // A write without the low byte lane completes but must leave the register alone.
    strobe = 4'he;
    wr(`BIAS_IDX, 8'h5a, `RESP_OKAY);
    strobe = 4'h1;
    wr(6'h3f, 8'h5a, `RESP_SLVERR);
    rd(6'h3f, 8'h00, `RESP_SLVERR);
    rd(`BIAS_IDX, 8'h20, `RESP_OKAY);
    $display("bias and bus test done");
  endtask

  // The master raises rready late here, so the answer must wait unchanged.
  task automatic testReadHold();
    int n;
    n = 0;
    @(posedge clk_sys);
    araddr <= {`ROUTE_IDX, 2'b00};
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 40);
    answered(rvalid);
    repeat (3) @(posedge clk_sys);
    rready <= 1'b1;
    @(posedge clk_sys);
    rready <= 1'b0;
    answered(rvalid);
    cmp(rdata, 32'h000000f0, "held read data");
    @(posedge clk_sys);
    cmp({31'h0, rvalid}, 32'h0, "read answer released");
    $display("read hold test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    testReset();
    testMagnitude();
    testRouting();
    testBias();
    testReadHold();
    complete_run();
  end
endmodule
